//--- mwts_sequencer.sv
// Purpose: Microstep wave sequencer: walks a differential quarter-wave
//          table and produces unscaled sine and cosine phase currents.
// Assumes: One clock pclk; step_pulse is a one-cycle synchronous strobe.
// Notes:   Phase currents follow the magnitude walk by one clock.
//
// What this block does
// - Wave table splits into four segments at the three borders.
// - Width code and table bit pick step -1..+3 between entries.
// - Width code n in bits 2n+1:2n applies to segment n.
// - Passing position zero loads start values into both currents.
// - Cosine offset bits 31:24 is signed; cosine starts at 256+offset.
// - Cosine start bits 23:16 hold value at position zero; reset 247.
// - Sine start bits 7:0 hold value of table entry zero.
// - Read-only 10-bit position for phase B; phase A adds 256.
// - Phase A current, 9 bits at 24:16, read-only, unscaled.
// - Phase B current, 9 bits at 8:0, read-only, unscaled.
// - One table bit per quarter-wave entry encodes entry difference.
`timescale 1ns/1ps
`include "mwts_regs.svh"
module mwts_sequencer
  import mwts_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [11:0]   paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          step_pulse,
  input  wire logic          step_dir,
  input  wire logic [255:0]  differential_wave_table,
  output logic      [9:0]    table_position_counter,
  output logic      [8:0]    phase_a_current,
  output logic      [8:0]    phase_b_current
);
  mwts_reg_if   rif ();

  logic [31:0]  wave_segment_select_q;
  logic [31:0]  wave_start_values_q;
  logic [9:0]   pos_d;
  logic         wrap_to_zero;
  logic [7:0]   cos_ofs;
  logic [9:0]   ph_pos   [2];
  mwts_mag_type mag_q    [2];
  mwts_mag_type mag_d    [2];
  mwts_mag_type load_val [2];

  ////////////////////////////////////////////////////////////////////////
  mwts_apb_slave u_bus (
    .pclk    (pclk),
    .presetn (presetn),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rb      (rif)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register file. Rewriting borders or widths mid-wave corrupts the
  // walk; software is expected to do it only at position zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_segment_select_q <= `MWTS_RST_SEGSEL;
    end else if (rif.wr_en && rif.idx == `MWTS_IDX_SEGSEL) begin
      wave_segment_select_q <= rif.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_start_values_q <= `MWTS_RST_START;
    end else if (rif.wr_en && rif.idx == `MWTS_IDX_START) begin
      wave_start_values_q <= rif.wdata & `MWTS_START_MASK;
    end
  end

  always_comb begin
    rif.hit   = 1'b1;
    rif.rdata = 32'h0;
    case (rif.idx)
      `MWTS_IDX_SEGSEL: rif.rdata = wave_segment_select_q;
      `MWTS_IDX_START:  rif.rdata = wave_start_values_q;
      `MWTS_IDX_POS:
        rif.rdata[`MWTS_F_POS] = table_position_counter;
      `MWTS_IDX_CUR: begin
        rif.rdata[`MWTS_F_PHASE_A_CUR] = phase_a_current;
        rif.rdata[`MWTS_F_PHASE_B_CUR] = phase_b_current;
      end
      default: rif.hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Position counter, free wrap over the full electrical turn.
  always_comb begin
    if (!step_pulse) begin
      pos_d = table_position_counter;
    end else if (step_dir) begin
      pos_d = table_position_counter + `MWTS_ONE_STEP;
    end else begin
      pos_d = table_position_counter - `MWTS_ONE_STEP;
    end
  end

  assign wrap_to_zero = step_pulse && (pos_d == `MWTS_RST_POS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_position_counter <= `MWTS_RST_POS;
    end else begin
      table_position_counter <= pos_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase B runs on the counter itself, phase A a quarter turn (one full
  // pass of the quarter table) further plus the signed cosine offset.
  assign cos_ofs   = wave_start_values_q[`MWTS_F_COS_OFS];
  assign ph_pos[0] = table_position_counter;
  assign ph_pos[1] = table_position_counter + `MWTS_HALF_TURN
                     + {{2{cos_ofs[7]}}, cos_ofs};

  assign load_val[0] = {1'b0, wave_start_values_q[`MWTS_F_SIN_START]};
  assign load_val[1] = {1'b0, wave_start_values_q[`MWTS_F_COS_START]};

  // Each phase walks its own magnitude. Of the two positions spanned by
  // a step, the lower one names the table bit; in a falling quarter the
  // entry is mirrored and the step reverses sign.
  for (genvar g = 0; g < 2; g++) begin : g_phase
    logic [9:0]     lo;
    logic           rising;
    logic [7:0]     entry;
    logic           plus;
    mwts_delta_type delta;
    mwts_mag_type   delta_ext;

    assign lo        = step_dir ? ph_pos[g] : ph_pos[g] - `MWTS_ONE_STEP;
    assign rising    = !lo[8];
    assign entry     = rising ? lo[7:0] : ~lo[7:0];
    assign plus      = (rising == step_dir);
    assign delta_ext = {{6{delta[2]}}, delta};

    mwts_step_decode u_dec (
      .first_border  (wave_segment_select_q[`MWTS_F_FIRST_BORDER]),
      .second_border (wave_segment_select_q[`MWTS_F_SECOND_BORDER]),
      .third_border  (wave_segment_select_q[`MWTS_F_THIRD_BORDER]),
      .widths        (wave_segment_select_q[`MWTS_F_WIDTHS]),
      .entry         (entry),
      .table_bit     (differential_wave_table[entry]),
      .delta         (delta)
    );

    always_comb begin
      if (wrap_to_zero) begin
        mag_d[g] = load_val[g];
      end else if (step_pulse && plus) begin
        mag_d[g] = mag_q[g] + delta_ext;
      end else if (step_pulse) begin
        mag_d[g] = mag_q[g] - delta_ext;
      end else begin
        mag_d[g] = mag_q[g];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mag_q[g] <= (g == 0) ? `MWTS_RST_MAG_B : `MWTS_RST_MAG_A;
      end else begin
        mag_q[g] <= mag_d[g];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Second half of the turn negates; registered so the outputs and the
  // readback come straight from flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_b_current <= `MWTS_RST_MAG_B;
      phase_a_current <= `MWTS_RST_MAG_A;
    end else begin
      phase_b_current <= ph_pos[0][9] ? -mag_q[0] : mag_q[0];
      phase_a_current <= ph_pos[1][9] ? -mag_q[1] : mag_q[1];
    end
  end
endmodule

//--- mwts_regs.svh
// Purpose: Register indices, field positions and reset values of the
//          microstep wave table sequencer.
// Assumes: Included by bare name; definitions only.
// Notes:   Byte address of a register is four times its index.
`ifndef MWTS_REGS_SVH
`define MWTS_REGS_SVH

`define MWTS_IDX_SEGSEL    8'h68
`define MWTS_IDX_START     8'h69
`define MWTS_IDX_POS       8'h6A
`define MWTS_IDX_CUR       8'h6B

`define MWTS_ADDR_IDX      9:2
`define MWTS_ADDR_HIGH     11:10
`define MWTS_ADDR_LANE     1:0

`define MWTS_RST_SEGSEL    32'hFFFF8056
`define MWTS_RST_START     32'h00F70000
`define MWTS_START_MASK    32'hFFFF00FF
`define MWTS_RST_POS       10'h000
`define MWTS_RST_MAG_B     9'h000
`define MWTS_RST_MAG_A     9'h0F7

`define MWTS_F_THIRD_BORDER  31:24
`define MWTS_F_SECOND_BORDER 23:16
`define MWTS_F_FIRST_BORDER  15:8
`define MWTS_F_WIDTHS      7:0
`define MWTS_F_COS_OFS     31:24
`define MWTS_F_COS_START   23:16
`define MWTS_F_SIN_START   7:0
`define MWTS_F_POS         9:0
`define MWTS_F_PHASE_A_CUR 24:16
`define MWTS_F_PHASE_B_CUR 8:0

`define MWTS_WCODE_BITS    2
`define MWTS_HALF_TURN     10'h100
`define MWTS_ONE_STEP      10'h001

`endif

//--- mwts_pkg.sv
// Purpose: Types shared by the microstep wave table sequencer.
// Assumes: Constants live in mwts_regs.svh.
// Notes:   None.
package mwts_pkg;
  typedef logic        [8:0] mwts_mag_type;
  typedef logic signed [2:0] mwts_delta_type;
  typedef logic        [7:0] mwts_idx_type;
  typedef enum {MWTS_BUS_IDLE, MWTS_BUS_ACCESS} mwts_bus_state_type;
endpackage

//--- mwts_reg_if.sv
// Purpose: Register access path between the bus slave and register file.
// Assumes: Single clock domain.
// Notes:   rdata and hit are combinational from the register file.
`timescale 1ns/1ps
interface mwts_reg_if;
  import mwts_pkg::*;
  logic         wr_en;
  mwts_idx_type idx;
  logic  [31:0] wdata;
  logic  [31:0] rdata;
  logic         hit;
  modport bus  (output wr_en, idx, wdata, input rdata, hit);
  modport regs (input wr_en, idx, wdata, output rdata, hit);
endinterface

//--- mwts_step_decode.sv
// Purpose: Turns one differential table bit into a signed entry step.
// Assumes: Borders are ordered by software; otherwise the result is
//          merely some legal step.
// Notes:   Pure combinational.
`timescale 1ns/1ps
`include "mwts_regs.svh"
module mwts_step_decode
  import mwts_pkg::*;
(
  input  wire logic [7:0]    first_border,
  input  wire logic [7:0]    second_border,
  input  wire logic [7:0]    third_border,
  input  wire logic [7:0]    widths,
  input  wire logic [7:0]    entry,
  input  wire logic          table_bit,
  output mwts_delta_type     delta
);
  logic [1:0] seg;
  logic [1:0] wcode;

  always_comb begin
    if (entry < first_border) begin
      seg = 2'h0;
    end else if (entry < second_border) begin
      seg = 2'h1;
    end else if (entry < third_border) begin
      seg = 2'h2;
    end else begin
      seg = 2'h3;
    end
    wcode = widths[{seg, 1'b0} +: `MWTS_WCODE_BITS];
    // Code minus one plus the bit gives -1..+3.
    delta = $signed({1'b0, wcode}) - 3'sh1
            + $signed({2'h0, table_bit});
  end
endmodule

//--- mwts_apb_slave.sv
// Purpose: APB slave front end; one access cycle, registered answer.
// Assumes: APB master keeps address and data stable during a transfer.
// Notes:   Unmapped or misaligned addresses answer with pslverr.
`timescale 1ns/1ps
`include "mwts_regs.svh"
module mwts_apb_slave
  import mwts_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [11:0]   paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  mwts_reg_if.bus            rb
);
  mwts_bus_state_type state_q;
  logic               ok;

  assign rb.idx   = paddr[`MWTS_ADDR_IDX];
  assign rb.wdata = pwdata;
  assign ok       = rb.hit && (paddr[`MWTS_ADDR_HIGH] == 2'h0)
                    && (paddr[`MWTS_ADDR_LANE] == 2'h0);
  // Writes land only at the completing edge of the access phase.
  assign rb.wr_en = (state_q == MWTS_BUS_ACCESS) && psel && penable
                    && pwrite && ok;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= MWTS_BUS_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      case (state_q)
        MWTS_BUS_IDLE: begin
          if (psel && !penable) begin
            state_q <= MWTS_BUS_ACCESS;
            pready  <= 1'b1;
            pslverr <= !ok;
            prdata  <= (!pwrite && ok) ? rb.rdata : 32'h0;
          end
        end
        MWTS_BUS_ACCESS: begin
          // Leaves also if the master aborts, so the slave never hangs.
          if (!(psel && !penable)) begin
            state_q <= MWTS_BUS_IDLE;
            pready  <= 1'b0;
            pslverr <= 1'b0;
          end
        end
        default: begin
          state_q <= MWTS_BUS_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end
endmodule

//--- mwts_seq_monitor.sv
// Purpose: Port assertions for the microstep wave table sequencer.
// Assumes: One clock pclk and the asynchronous reset presetn.
// Notes:   Bound to every instance at the foot of this file.
`timescale 1ns/1ps
module mwts_seq_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        step_pulse,
  input wire logic        step_dir,
  input wire logic [9:0]  table_position_counter,
  input wire logic [8:0]  phase_a_current,
  input wire logic [8:0]  phase_b_current
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup_w = psel & ~penable;
  ////////////////////////////////////////
  a_ready_after_setup: assert property (setup_w |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_refused_read_zero: assert property (
    pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read data not zero");
  a_high_addr_err: assert property (
    setup_w && paddr[11:10] != 2'h0 |=> pslverr)
    else $error("high address not refused");
  a_mapped_no_err: assert property (
    setup_w && paddr[11:4] == 8'h1A && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped address refused");
  a_pos_forward: assert property (
    step_pulse && step_dir |=> table_position_counter ==
      $past(table_position_counter) + 10'h001)
    else $error("position did not advance");
  a_pos_backward: assert property (
    step_pulse && !step_dir |=> table_position_counter ==
      $past(table_position_counter) - 10'h001)
    else $error("position did not retreat");
  a_pos_hold: assert property (
    !step_pulse |=> $stable(table_position_counter))
    else $error("position moved without a step");
  a_currents_quiet: assert property (
    !step_pulse [*2] |=> $stable(phase_a_current) &&
      $stable(phase_b_current))
    else $error("currents moved without a step");
endmodule

bind mwts_sequencer mwts_seq_monitor mon (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .prdata, .pready,
  .pslverr, .step_pulse, .step_dir, .table_position_counter,
  .phase_a_current, .phase_b_current
);

//--- tb.sv
// Purpose: Self-checking bench for the microstep wave table sequencer.
// Assumes: APB slave answers within the global cycle ceiling.
// Notes:   The walk expectation is rebuilt from the width coding.
`timescale 1ns/1ps
module tb;
  localparam int LIMIT = 9000;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         step_pulse = 1'b0;
  logic         step_dir = 1'b0;
  logic [255:0] tbl = {64{4'hA}};
  logic [9:0]   pos;
  logic [8:0]   phs_a;
  logic [8:0]   phs_b;
  logic [31:0]  rd;
  logic         er;
  logic [8:0]   m [0:256];
  int           err_count = 0;
  int           n_tests = 0;
  int           cycles = 0;

  always #25 pclk = ~pclk;

  mwts_sequencer uut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .step_pulse, .step_dir,
    .differential_wave_table(tbl), .table_position_counter(pos),
    .phase_a_current(phs_a), .phase_b_current(phs_b)
  );
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp,
                      input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
    chk({31'h0, er}, 32'h0, "read refused");
  endtask

  // Currents lag the step edge by one clock, so wait for that too.
  task automatic step(input logic d);
    @(posedge pclk);
    step_pulse <= 1'b1;
    step_dir   <= d;
    @(posedge pclk);
    step_pulse <= 1'b0;
    @(posedge pclk);
    #1;
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    chk({22'h0, pos}, 32'h0, "pos port");
    chk({23'h0, phs_a}, 32'hF7, "phase_a_current port");
    rchk(12'h1A0, 32'hFFFF8056, "segsel");
    rchk(12'h1A4, 32'h00F70000, "start");
    rchk(12'h1A8, 32'h0, "pos reg");
    rchk(12'h1AC, 32'h00F70000, "cur reg");
    $display("test reset done");
  endtask

  task automatic t_regs;
    logic [11:0] bad [3] = '{12'h1B0, 12'h1A2, 12'h5A0};
    apb(1'b1, 12'h1A4, 32'h85ABCD12);
    rchk(12'h1A4, 32'h85AB0012, "start rw");
    apb(1'b1, 12'h5A4, 32'h0);
    rchk(12'h1A4, 32'h85AB0012, "alias write");
    apb(1'b1, 12'h1A8, 32'hFFFFFFFF);
    chk({31'h0, er}, 32'h0, "ro write");
    rchk(12'h1A8, 32'h0, "pos ro");
    apb(1'b1, 12'h1AC, 32'hFFFFFFFF);
    rchk(12'h1AC, 32'h00F70000, "cur ro");
    foreach (bad[i]) begin
      apb(1'b0, bad[i], 32'h0);
      chk({31'h0, er}, 32'h1, "bad addr err");
      chk(rd, 32'h0, "bad addr data");
    end
    $display("test regs done");
  endtask

  task automatic t_load;
    apb(1'b1, 12'h1A0, 32'hC08040E4);
    apb(1'b1, 12'h1A4, 32'h00300080);
    step(1'b0);
    chk({22'h0, pos}, 32'h3FF, "wrap back");
    step(1'b1);
    chk({22'h0, pos}, 32'h0, "pos zero");
    chk({23'h0, phs_b}, 32'h080, "sin load");
    chk({23'h0, phs_a}, 32'h030, "cos load");
    rchk(12'h1AC, 32'h00300080, "cur reg");
    $display("test load done");
  endtask

  // Width codes 0..3 sit in segments 0..3; the bits alternate 0,1.
  task automatic t_walk;
    int         p;
    int         s;
    logic [1:0] code;
    m[0] = 9'h080;
    for (p = 0; p < 255; p++) begin
      s = int'(p >= 64) + int'(p >= 128) + int'(p >= 192);
      code = 2'(s);
      m[p+1] = m[p] + {7'h0, code} + {8'h0, tbl[p]} - 9'h001;
      step(1'b1);
      chk({23'h0, phs_b}, {23'h0, m[p+1]}, "walk up");
    end
    for (p = 255; p > 1; p--) begin
      step(1'b0);
      chk({23'h0, phs_b}, {23'h0, m[p-1]}, "walk down");
    end
    $display("test walk done");
  endtask

  // Odd quarters mirror the first; the second half of a turn negates.
  function automatic logic [8:0] tmag(input logic [9:0] x);
    return x[8] ? m[9'h100 - {1'b0, x[7:0]}] : m[x[7:0]];
  endfunction

  // One full turn forward with a cosine offset of minus sixteen steps.
  task automatic t_turn;
    int         i;
    logic [9:0] a;
    logic [8:0] e;
    // Width code three gives a step of two plus the table bit.
    m[256] = m[255] + 9'h002 + {8'h0, tbl[255]};
    step(1'b0);
    chk({22'h0, pos}, 32'h0, "turn start");
    apb(1'b1, 12'h1A4, 32'hF0300080);
    for (i = 1; i <= 1024; i++) begin
      step(1'b1);
      a = 10'(i);
      e = a[9] ? -tmag(a) : tmag(a);
      chk({23'h0, phs_b}, {23'h0, e}, "turn b");
      a = a + 10'h0F0;
      e = 9'h030 + tmag(a) - tmag(10'h0F0);
      e = a[9] ? -e : e;
      chk({23'h0, phs_a}, {23'h0, e}, "turn a");
    end
    $display("test turn done");
  endtask
  ////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles > LIMIT) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_load();
    t_walk();
    t_turn();
    tally_and_finish();
  end
endmodule
